// ### itw_master.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Processor-side model: one register access per call, one strobe cycle each
module itw_master (
   input wire logic i_mclk,
   output logic [2:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [15:0] o_wdata
);
   // Idle bus at time zero, no strobe
   initial begin
      o_addr = 3'h7;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 16'hA5A5;
   end

   // Drive just after an edge, hold through the taking edge, then release
   task automatic access(input logic [2:0] a, input logic w,
                         input logic [15:0] d);
      @(posedge i_mclk);
      #1;
      o_addr = a;
      o_wr = w;
      o_rd = ~w;
      o_wdata = d;
      @(posedge i_mclk);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      // Released lines flip so a stale value can never look valid
      o_addr = ~a;
      o_wdata = ~d;
   endtask
endmodule

// ### itw_pkg.sv
package itw_pkg;
   // Register indices on the 16-bit slave port
   localparam logic [2:0] ITW_IDX_STATUS = 3'h0;
   localparam logic [2:0] ITW_IDX_CONTROL = 3'h1;
   localparam logic [2:0] ITW_IDX_PERIODL = 3'h2;
   localparam logic [2:0] ITW_IDX_PERIODH = 3'h3;
   localparam logic [2:0] ITW_IDX_SNAPL = 3'h4;
   localparam logic [2:0] ITW_IDX_SNAPH = 3'h5;
   // Field positions
   localparam int ITW_ST_EXPIRED = 0;
   localparam int ITW_ST_RUN = 1;
   localparam int ITW_CT_IRQ_EN = 0;
   localparam int ITW_CT_REPEAT = 1;
   localparam int ITW_CT_START = 2;
   localparam int ITW_CT_STOP = 3;
   // Reset values
   localparam logic [3:0] ITW_CTRL_RST = 4'h0;
   localparam logic [15:0] ITW_UNDEF_RD = 16'h0000;
   // Clock rate and period units
   localparam longint ITW_CLK_HZ = 25000000;
   typedef enum {ITW_U_CLK, ITW_U_US, ITW_U_MS, ITW_U_S} itw_unit_t;

   // Period in cycles, rounded up to whole cycles
   function automatic logic [31:0] itw_cycles(input longint val,
                                               input itw_unit_t u);
      longint div;
      longint cyc;
      div = 1;
      unique case (u)
         ITW_U_CLK: div = 0;
         ITW_U_US: div = 1000000;
         ITW_U_MS: div = 1000;
         ITW_U_S: div = 1;
      endcase
      if (div == 0) begin
         cyc = val;
      end else begin
         cyc = (val * ITW_CLK_HZ + div - 1) / div;
      end
      if (cyc < 1) begin
         cyc = 1;
      end
      return cyc[31:0];
   endfunction
endpackage

// ### itw_snap.sv
`timescale 1ns/100ps
// Coherent counter snapshot held in a register pair, plus the read register
module itw_snap (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_take,
   input wire logic [31:0] i_count,
   input wire logic i_sel_hi,
   input wire logic i_rd,
   input wire logic i_pick_snap,
   input wire logic [15:0] i_regdata,
   output logic [15:0] o_rdata
);
   logic [31:0] snap_r;
   logic [15:0] rd_r;

   // Half chosen by the read address
   wire [15:0] snap_half = i_sel_hi ? snap_r[31:16] : snap_r[15:0];

   // Both halves captured together so a later read is coherent; read data
   // only move on a read strobe, so they hold until the next read
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         snap_r <= 32'h00000000;
         rd_r <= 16'h0000;
      end else begin
         if (i_take) begin
            snap_r <= i_count;
         end
         if (i_rd) begin
            rd_r <= i_pick_snap ? snap_half : i_regdata;
         end
      end
   end
   assign o_rdata = rd_r;
endmodule

// ### itw_timer.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Period registers reset to the build-time timeout period in cycles, minus one.
// - Writable period option lets writes to period halves change it.
// - Time-unit periods round up to whole clock cycles.
// - Without snapshot option, snapshot reads return undefined data.
// - Start and stop bits control counting; otherwise counter runs freely.
// - Watchdog option keeps the start bit even without start/stop.
// - Timeout strobe pulses high one cycle at each zero.
// - Watchdog restart request pulses one cycle at each zero.
// - Watchdog counter halted after reset until start bit written.
// - Started watchdog cannot be halted by any write.
// - Watchdog: any period write reloads fixed period; the kick ignores data, but a writable period still stores it.
// - Watchdog preset drops period, snapshot, start/stop, strobe options.
// - Counter reloads from the period registers immediately at zero.
// - With start/stop and no watchdog, repeat bit clear halts after zero; set keeps running.
// - Interrupt asserted while expired flag and enable bit both set.
// - Expired flag set at zero, held until status written zero.
module itw_timer
   import itw_pkg::*;
#(
   parameter bit PRESET_WDOG = 1'b0,
   parameter longint PERIOD_VAL = 1000,
   parameter itw_pkg::itw_unit_t PERIOD_UNIT = itw_pkg::ITW_U_US,
   parameter bit OPT_WR_PERIOD = 1'b1,
   parameter bit OPT_SNAPSHOT = 1'b1,
   parameter bit OPT_STARTSTOP = 1'b1,
   parameter bit OPT_PULSE = 1'b1,
   parameter bit OPT_WDOG = 1'b0
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic [2:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata,
   output logic o_irq,
   output logic o_timeout_pulse,
   output logic o_reset_request
);
   import itw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Effective options; the watchdog preset overrides the rest
   localparam bit WDOG = PRESET_WDOG | OPT_WDOG;
   localparam bit WR_PER = OPT_WR_PERIOD & !PRESET_WDOG;
   localparam bit SNAP = OPT_SNAPSHOT & !PRESET_WDOG;
   localparam bit SS = OPT_STARTSTOP & !PRESET_WDOG;
   localparam bit PULSE = OPT_PULSE & !PRESET_WDOG;
   localparam bit HAS_START = SS | WDOG;
   // Reload value is the cycle count minus one, giving an exact period
   localparam logic [31:0] PERIOD_CYC = itw_cycles(PERIOD_VAL, PERIOD_UNIT);
   localparam logic [31:0] RELOAD_RST = PERIOD_CYC - 32'h00000001;
   localparam bit RUN_RST = !WDOG && !SS; // Free running when uncontrolled

   logic [31:0] period_r;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic run_r;
   logic run_nxt;
   logic expired_r;
   logic irq_en_r;
   logic repeat_r;
   logic zero_evt_r;
   logic irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_stat = i_wr && (i_addr == ITW_IDX_STATUS);
   wire wr_ctrl = i_wr && (i_addr == ITW_IDX_CONTROL);
   wire wr_perl = i_wr && (i_addr == ITW_IDX_PERIODL);
   wire wr_perh = i_wr && (i_addr == ITW_IDX_PERIODH);
   wire wr_snap = i_wr && ((i_addr == ITW_IDX_SNAPL) ||
                           (i_addr == ITW_IDX_SNAPH));
   wire wr_per = wr_perl || wr_perh;
   wire start_cmd = HAS_START && wr_ctrl && i_wdata[ITW_CT_START];
   // Stop is refused in watchdog mode so nothing halts a started dog
   wire stop_cmd = SS && !WDOG && wr_ctrl && i_wdata[ITW_CT_STOP];
   wire at_zero = run_r && (count_r == 32'h00000000);
   // A watchdog or a free runner never halts; with start/stop, a clear repeat bit halts it
   wire halt_at_zero = at_zero && !repeat_r && !WDOG && SS;
   wire dog_kick = WDOG && wr_per;

   ////////////////////////////////////////////////////////////////////////////
   // Period registers, writable only with the option
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         period_r <= RELOAD_RST;
      end else if (WR_PER && wr_perl) begin
         period_r[15:0] <= i_wdata;
      end else if (WR_PER && wr_perh) begin
         period_r[31:16] <= i_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter next value: reload at zero, kick, or period write
   always_comb begin
      count_nxt = count_r;
      if (dog_kick) begin
         count_nxt = RELOAD_RST;
      end else if (WR_PER && wr_perl) begin
         count_nxt = {period_r[31:16], i_wdata};
      end else if (WR_PER && wr_perh) begin
         count_nxt = {i_wdata, period_r[15:0]};
      end else if (at_zero) begin
         count_nxt = period_r;
      end else if (run_r) begin
         count_nxt = count_r - 32'h00000001;
      end
   end

   // Run state; watchdog starts halted and ignores stop once going
   always_comb begin
      run_nxt = run_r;
      if (halt_at_zero || stop_cmd) begin
         run_nxt = 1'b0;
      end
      if (start_cmd) begin
         run_nxt = 1'b1;
      end
      if (!HAS_START) begin
         run_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_r <= RELOAD_RST;
         run_r <= RUN_RST;
      end else begin
         count_r <= count_nxt;
         run_r <= run_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control bits and the sticky expired flag; a set beats a clear
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_en_r <= ITW_CTRL_RST[ITW_CT_IRQ_EN];
         repeat_r <= ITW_CTRL_RST[ITW_CT_REPEAT];
         expired_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            irq_en_r <= i_wdata[ITW_CT_IRQ_EN];
            repeat_r <= i_wdata[ITW_CT_REPEAT];
         end
         if (at_zero) begin
            expired_r <= 1'b1;
         end else if (wr_stat && i_wdata == 16'h0000) begin
            expired_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs: zero strobes and level interrupt
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         zero_evt_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         zero_evt_r <= at_zero;
         irq_r <= irq_en_r && expired_r;
      end
   end
   assign o_timeout_pulse = PULSE ? zero_evt_r : 1'b0;
   assign o_reset_request = WDOG ? zero_evt_r : 1'b0;
   assign o_irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; data valid one cycle after i_rd
   wire [15:0] stat_rd = {14'h0000, run_r, expired_r};
   wire [15:0] ctrl_rd = {14'h0000, repeat_r, irq_en_r};
   wire [15:0] reg_rd =
      (i_addr == ITW_IDX_STATUS) ? stat_rd :
      (i_addr == ITW_IDX_CONTROL) ? ctrl_rd :
      (i_addr == ITW_IDX_PERIODL && WR_PER) ? period_r[15:0] :
      (i_addr == ITW_IDX_PERIODH && WR_PER) ? period_r[31:16] :
      ITW_UNDEF_RD;
   // Absent snapshot halves fall through to the undefined-read value
   wire pick_snap = SNAP && (i_addr == ITW_IDX_SNAPL ||
                             i_addr == ITW_IDX_SNAPH);

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot store, taken on any write to either snapshot half. It also
   // owns the read register, so o_rdata leaves from one flip-flop
   itw_snap u_snap (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_take(SNAP && wr_snap),
      .i_count(count_r),
      .i_sel_hi(i_addr == ITW_IDX_SNAPH),
      .i_rd(i_rd),
      .i_pick_snap(pick_snap),
      .i_regdata(reg_rd),
      .o_rdata(o_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_strobe_once: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_timeout_pulse |=> !o_timeout_pulse || $past(at_zero))
      else $error("timeout strobe held without a zero");
   a_strobe_cause: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      at_zero |=> (o_timeout_pulse == PULSE))
      else $error("timeout strobe missing after zero");
   a_dog_req: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      at_zero |=> (o_reset_request == WDOG))
      else $error("restart request wrong after zero");
   a_reload_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      at_zero && !i_wr |=> count_r == $past(period_r))
      else $error("counter not reloaded at zero");
   a_count_dec: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      run_r && !at_zero && !i_wr |=> count_r == $past(count_r) - 1)
      else $error("counter did not decrement");
   a_dog_stays: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      WDOG && run_r |=> run_r)
      else $error("watchdog halted after start");
   a_dog_kick: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      dog_kick |=> count_r == RELOAD_RST)
      else $error("watchdog kick did not reload");
   // Zero event: the flag rises, then the interrupt follows the enable
   sequence s_flag_then_irq;
      expired_r ##1 (irq_r == $past(irq_en_r));
   endsequence
   a_expired_set: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      at_zero |=> s_flag_then_irq)
      else $error("expired flag or irq wrong");
   a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_irq |-> $past(irq_en_r) && $past(expired_r))
      else $error("irq without flag and enable");
   a_no_stop: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      !HAS_START |-> run_r)
      else $error("uncontrolled counter stopped");
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import itw_pkg::*;
   logic i_mclk;
   logic i_arst_n;
   logic [2:0] a0, a1;
   logic w0, w1, r0, r1, irq0, irq1, tp0, tp1, rq0, rq1, r0_d, r1_d, tp0_d;
   logic [15:0] d0, d1, q0, q1, rv, rh;
   logic [15:0] expq[$];
   int num_errors = 0;
   int compares = 0;
   int n, tp0_cnt = 0, rq1_cnt = 0, tp1_cnt = 0, rq0_cnt = 0, base;

   ////////////////////////////////////////////////////////////////////////////
   // Full-featured timer with a short clock-count period, and a watchdog
   itw_master m0 (.i_mclk(i_mclk), .o_addr(a0), .o_wr(w0), .o_rd(r0),
                  .o_wdata(d0));
   itw_master m1 (.i_mclk(i_mclk), .o_addr(a1), .o_wr(w1), .o_rd(r1),
                  .o_wdata(d1));
   itw_timer #(.PERIOD_VAL(20), .PERIOD_UNIT(ITW_U_CLK)) dut (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(a0), .i_wr(w0),
      .i_rd(r0), .i_wdata(d0), .o_rdata(q0), .o_irq(irq0),
      .o_timeout_pulse(tp0), .o_reset_request(rq0));
   // Watchdog preset over the default options, which it must mask;
   // a 1 us period rounds to 25 clocks
   itw_timer #(.PRESET_WDOG(1'b1), .PERIOD_VAL(1)) dut_wd (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(a1), .i_wr(w1),
      .i_rd(r1), .i_wdata(d1), .o_rdata(q1), .o_irq(irq1),
      .o_timeout_pulse(tp1), .o_reset_request(rq1));

   // 25 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Reads note their expectation first; the monitor pops it later
   task automatic rd(input bit wd, input logic [2:0] a, input logic [15:0] e);
      expq.push_back(e);
      if (wd) m1.access(a, 1'b0, 16'h0000);
      else m0.access(a, 1'b0, 16'h0000);
   endtask

   task automatic wr(input bit wd, input logic [2:0] a, input logic [15:0] d);
      if (wd) m1.access(a, 1'b1, d);
      else m0.access(a, 1'b1, d);
   endtask

   // Counts falling edges until the chosen strobe shows, bounded by lim
   task automatic wait_ev(input bit wd, input int lim, output int cyc);
      cyc = 0;
      do begin
         @(negedge i_mclk);
         cyc++;
      end while (((wd ? rq1 : tp0) !== 1'b1) && cyc < lim);
      // A strobe that never came is a failure, not a silent timeout
      if ((wd ? rq1 : tp0) !== 1'b1) begin
         num_errors++;
         $display("mismatch at %0t: strobe never came", $time);
      end
   endtask

   // Monitor on the falling edge, one full cycle after each read strobe,
   // so read data has long settled whatever its exact launch edge
   always @(negedge i_mclk) begin
      if (r0_d === 1'b1) chk(q0, expq.pop_front(), "read data");
      if (r1_d === 1'b1) chk(q1, expq.pop_front(), "watchdog read data");
      if (tp0_d === 1'b1) chk({15'h0, tp0}, 16'h0000, "strobe width");
      if (tp0 === 1'b1) tp0_cnt++;
      if (tp1 === 1'b1) tp1_cnt++;
      if (rq1 === 1'b1) rq1_cnt++;
      if (rq0 === 1'b1) rq0_cnt++;
      r0_d <= r0;
      r1_d <= r1;
      tp0_d <= tp0;
   end

   // Hang guard: the whole sequence needs well under 2000 cycles
   initial begin
      #(40 * 4000);
      num_errors++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_arst_n = 1'b0;
      void'($urandom(32'h24A1));
      repeat (12) @(posedge i_mclk);
      #1;
      i_arst_n = 1'b1;
      rd(0, ITW_IDX_PERIODL, 16'h0013);
      rd(0, ITW_IDX_PERIODH, 16'h0000);
      rd(0, ITW_IDX_STATUS, 16'h0000);
      rd(0, ITW_IDX_CONTROL, 16'h0000);
      $display("test reset values done");
      wr(0, ITW_IDX_PERIODL, 16'h0009);
      wr(0, ITW_IDX_PERIODH, 16'h0000);
      wr(0, ITW_IDX_CONTROL, 16'h0007);
      wait_ev(0, 40, n);
      wait_ev(0, 40, n);
      chk(16'(n), 16'h000A, "pulse spacing");
      repeat (2) @(negedge i_mclk);
      chk({15'h0, irq0}, 16'h0001, "irq raised");
      rd(0, ITW_IDX_CONTROL, 16'h0003);
      wr(0, ITW_IDX_CONTROL, 16'h0002);
      repeat (3) @(negedge i_mclk);
      chk({15'h0, irq0}, 16'h0000, "irq masked");
      rd(0, ITW_IDX_STATUS, 16'h0003);
      $display("test periodic run done");
      wr(0, ITW_IDX_CONTROL, 16'h000A);
      rv = 16'($urandom);
      rh = 16'($urandom);
      wr(0, ITW_IDX_PERIODL, rv);
      wr(0, ITW_IDX_PERIODH, rh);
      wr(0, ITW_IDX_SNAPH, 16'h0000);
      rd(0, ITW_IDX_SNAPL, rv);
      rd(0, ITW_IDX_SNAPH, rh);
      rd(0, ITW_IDX_STATUS, 16'h0001);
      wr(0, ITW_IDX_STATUS, 16'h0000);
      rd(0, ITW_IDX_STATUS, 16'h0000);
      $display("test stop and snapshot done");
      wr(0, ITW_IDX_PERIODH, 16'h0000);
      wr(0, ITW_IDX_PERIODL, 16'h0005);
      wr(0, ITW_IDX_CONTROL, 16'h0005);
      wait_ev(0, 20, n);
      // Step past the strobe edge so the monitor has counted it already
      @(negedge i_mclk);
      base = tp0_cnt;
      repeat (30) @(negedge i_mclk);
      chk(16'(tp0_cnt - base), 16'h0000, "one-shot stopped");
      chk({15'h0, irq0}, 16'h0001, "irq held");
      rd(0, ITW_IDX_STATUS, 16'h0001);
      $display("test one-shot done");
      chk(16'(rq1_cnt), 16'h0000, "watchdog idle after reset");
      rd(1, ITW_IDX_STATUS, 16'h0000);
      wr(1, ITW_IDX_CONTROL, 16'h0006);
      // Kick well inside the period with arbitrary data
      for (int i = 0; i < 6; i++) begin
         repeat (12) @(negedge i_mclk);
         wr(1, i[0] ? ITW_IDX_PERIODH : ITW_IDX_PERIODL, 16'($urandom));
      end
      chk(16'(rq1_cnt), 16'h0000, "kicks hold off request");
      wr(1, ITW_IDX_CONTROL, 16'h0008);
      rd(1, ITW_IDX_STATUS, 16'h0002);
      rd(1, ITW_IDX_SNAPL, 16'h0000);
      wait_ev(1, 40, n);
      // One more edge so the monitor has counted this request
      @(negedge i_mclk);
      chk(16'(rq1_cnt), 16'h0001, "request after missed kick");
      // 25 clocks between requests, less the edge stepped above
      wait_ev(1, 40, n);
      chk(16'(n), 16'h0018, "request spacing");
      chk(16'(tp1_cnt), 16'h0000, "no strobe in watchdog");
      chk({15'h0, irq1}, 16'h0000, "watchdog irq masked");
      rd(1, ITW_IDX_STATUS, 16'h0003);
      chk(16'(rq0_cnt), 16'h0000, "no request without watchdog");
      // Let the monitor take the last read before the verdict
      repeat (2) @(negedge i_mclk);
      $display("test watchdog done");
      tally_and_finish();
   end
endmodule
